// File: rtl/lcc_config_regs.sv
/*
  Configuration register bank for one span of a dual lane
  redriver: lane 0 output idle/rate, swing and de-emphasis,
  equalizer and idle thresholds of two inputs, pin override.
  Assumes an SMBus target front end turns bus transactions
  into single-cycle read and write strobes on clk_sys, and
  that pin and detector inputs are synchronous to clk_sys.
*/
`timescale 1ns/10ps

// Summary of operation
// [RULE1] Auto idle: mute follows own idle detector
// [RULE2] Manual idle set: output lane held muted
// [RULE3] Manual idle clear: output on, detection off
// [RULE4] Auto rate: detected rate range used
// [RULE5] Manual rate: bit0 picks low/high range
// [RULE6] Equalizer: enable, gain stage, boost fields
// [RULE7] Equalizer offers 24 gain/boost settings
// [RULE8] Code 0x20 is bypass and reset default
// [RULE9] Equalizer codes map to documented boost
// [RULE10] Swing codes 600 to 1200 mV, 0x3F reserved
// [RULE11] De-emphasis bit7 style, bits 6:0 level
// [RULE12] De-emphasis codes map to documented levels
// [RULE13] Threshold: bits3:2 de-assert, 1:0 assert
// [RULE14] Threshold codes map to documented voltages
// [RULE15] Each input holds its own equalizer register
// [RULE16] Lane 0 swing and de-emphasis reset 0x03
// [RULE17] Override bits block idle and rate pins
// [RULE18] Reserved bits written zero, kept inert
// [RULE19] Registers reset to defaults, hold writes
module lcc_config_regs (
  // Clock and reset
  input  logic                    clk_sys,
  input  logic                    rstn,
  // Register access strobes
  input  logic [lcc_pkg::AW-1:0]  reg_addr,
  input  logic [lcc_pkg::DW-1:0]  reg_wdata,
  input  logic                    reg_wr,
  input  logic                    reg_rd,
  output logic [lcc_pkg::DW-1:0]  reg_rdata,
  output logic                    reg_hit,
  // Control pins and detectors
  input  logic                    idle_pin,
  input  logic                    rate_pin,
  input  logic                    elec_idle_det,
  input  logic                    rate_det_hi,
  // Output lane 0 controls
  output logic                    out_lane0_mute,
  output logic                    out_lane0_signal_detection_en,
  output logic                    out_lane0_rate_hi,
  output logic [6:0]              out_lane0_output_swing,
  output logic                    out_lane0_swing_rsvd,
  output logic                    out_lane0_deemphasis_style,
  output logic [6:0]              out_lane0_deemphasis,
  // Input B lane 0 controls
  output logic                    in_b_lane0_equalizer_en,
  output logic [1:0]              in_b_lane0_gain_stage,
  output logic [2:0]              in_b_lane0_boost_level,
  output logic                    in_b_lane0_bypass,
  output logic [1:0]              in_b_lane0_idle_deassert,
  output logic [1:0]              in_b_lane0_idle_assert,
  // Input A lane 1 controls
  output logic                    in_a_lane1_equalizer_en,
  output logic [1:0]              in_a_lane1_gain_stage,
  output logic [2:0]              in_a_lane1_boost_level,
  output logic                    in_a_lane1_bypass,
  output logic [1:0]              in_a_lane1_idle_deassert,
  output logic [1:0]              in_a_lane1_idle_assert
);
  import lcc_pkg::*;

  // ---------------------------------------------
  // Storage and decode
  // ---------------------------------------------
  logic [DW-1:0] regs_r [NSLOT];  // Register contents
  logic          sel_hit;         // Offset is mapped
  logic [SW-1:0] sel_idx;         // Matching slot
  logic [DW-1:0] rdata_r;         // Read data flop
  logic          mute_r;          // Lane 0 mute state
  logic          mute_nxt;
  logic          sdet_r;          // Detection enable
  logic          sdet_nxt;
  logic          rate_r;          // High rate range
  logic          rate_nxt;
  logic          man_idle;        // Pin or register mute
  logic          man_rate;        // Pin or register rate

  // Offset to slot lookup
  always_comb begin
    sel_hit = 1'b0;
    sel_idx = '0;
    for (int s = 0; s < NSLOT; s++) begin
      if (reg_addr == SLOT_OFS[s]) begin
        sel_hit = 1'b1;
        sel_idx = SW'(s);
      end
    end
  end

  // Handshake: access lands on a mapped offset
  assign reg_hit = sel_hit & (reg_wr | reg_rd);

  // ---------------------------------------------
  // Register slots
  // ---------------------------------------------
  // Whole byte is stored, reserved bits included, so
  // software reads back what it wrote; they steer nothing.
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        regs_r[s] <= SLOT_RST[s];  // RULE19 RULE8 RULE16
      end else if (reg_wr && sel_hit && sel_idx == SW'(s)) begin
        regs_r[s] <= reg_wdata;  // RULE18 RULE19
      end
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= sel_hit ? regs_r[sel_idx] : '0;
    end
  end
  assign reg_rdata = rdata_r;

  // ---------------------------------------------
  // Output lane 0 idle and rate
  // ---------------------------------------------
  // Pins act unless the override bit blocks them
  always_comb begin
    man_idle = regs_r[SL_OVR][OV_IDLE] ?
               regs_r[SL_IR][IR_ISEL] : idle_pin;  // RULE17
    man_rate = regs_r[SL_OVR][OV_RATE] ?
               regs_r[SL_IR][IR_RSEL] : rate_pin;  // RULE17
  end

  // Mute source: detector in auto, else manual level
  always_comb begin
    if (regs_r[SL_IR][IR_IAUTO]) begin
      mute_nxt = elec_idle_det;  // RULE1
      sdet_nxt = 1'b1;
    end else if (man_idle) begin
      mute_nxt = 1'b1;  // RULE2
      sdet_nxt = 1'b0;
    end else begin
      mute_nxt = 1'b0;  // RULE3
      sdet_nxt = 1'b0;
    end
  end

  // Rate source: detector in auto, else manual bit
  always_comb begin
    if (regs_r[SL_IR][IR_RAUTO]) begin
      rate_nxt = rate_det_hi;  // RULE4
    end else begin
      rate_nxt = man_rate;  // RULE5
    end
  end

  // Lane controls are flopped; one cycle behind sources
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mute_r <= 1'b0;
      sdet_r <= 1'b0;
      rate_r <= 1'b0;
    end else begin
      mute_r <= mute_nxt;
      sdet_r <= sdet_nxt;
      rate_r <= rate_nxt;
    end
  end

  assign out_lane0_mute                = mute_r;
  assign out_lane0_signal_detection_en = sdet_r;
  assign out_lane0_rate_hi             = rate_r;

  // ---------------------------------------------
  // Swing and de-emphasis
  // ---------------------------------------------
  // Codes go to the analog driver as written; the
  // driver owns the code to millivolt mapping.
  assign out_lane0_output_swing = regs_r[SL_SWG][6:0];  // RULE10
  assign out_lane0_swing_rsvd =
    (regs_r[SL_SWG][6:0] == SWG_RSVD);  // RULE10
  assign out_lane0_deemphasis_style =
    regs_r[SL_DEM][DE_STYLE];  // RULE11 RULE12
  assign out_lane0_deemphasis = regs_r[SL_DEM][6:0];  // RULE11

  // ---------------------------------------------
  // Input equalizers and idle thresholds
  // ---------------------------------------------
  // Separate slots per input, identical field coding;
  // the 24 gain/boost codes pass straight to the CTLE.
  assign in_b_lane0_equalizer_en =
    regs_r[SL_EQB][EQ_EN];  // RULE6 RULE15
  assign in_b_lane0_gain_stage =
    regs_r[SL_EQB][EQ_GS_LSB +: 2];  // RULE6 RULE7 RULE9
  assign in_b_lane0_boost_level =
    regs_r[SL_EQB][2:0];  // RULE6 RULE7 RULE9
  assign in_b_lane0_bypass =
    (regs_r[SL_EQB][5:0] == EQ_BYPASS);  // RULE8
  assign in_a_lane1_equalizer_en =
    regs_r[SL_EQA][EQ_EN];  // RULE6 RULE15
  assign in_a_lane1_gain_stage =
    regs_r[SL_EQA][EQ_GS_LSB +: 2];  // RULE6 RULE7 RULE9
  assign in_a_lane1_boost_level =
    regs_r[SL_EQA][2:0];  // RULE6 RULE7 RULE9
  assign in_a_lane1_bypass =
    (regs_r[SL_EQA][5:0] == EQ_BYPASS);  // RULE8

  // Threshold pairs; the comparator maps them to mV
  assign in_b_lane0_idle_deassert =
    regs_r[SL_THB][TH_DA_LSB +: 2];  // RULE13 RULE14
  assign in_b_lane0_idle_assert =
    regs_r[SL_THB][1:0];  // RULE13 RULE14
  assign in_a_lane1_idle_deassert =
    regs_r[SL_THA][TH_DA_LSB +: 2];  // RULE13 RULE14
  assign in_a_lane1_idle_assert =
    regs_r[SL_THA][1:0];  // RULE13 RULE14

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  AST_AUTO_IDLE: assert property (  // RULE1
    @(posedge clk_sys) disable iff (!rstn)
    regs_r[SL_IR][IR_IAUTO] |=>
      out_lane0_mute == $past(elec_idle_det))
    else $error("auto idle mute mismatch");

  AST_MANUAL_MUTE: assert property (  // RULE2
    @(posedge clk_sys) disable iff (!rstn)
    !regs_r[SL_IR][IR_IAUTO] && man_idle |=>
      out_lane0_mute && !out_lane0_signal_detection_en)
    else $error("manual idle not muted");

  AST_DRIVE_ON: assert property (  // RULE3
    @(posedge clk_sys) disable iff (!rstn)
    !regs_r[SL_IR][IR_IAUTO] && !man_idle |=>
      !out_lane0_mute && !out_lane0_signal_detection_en)
    else $error("output not driving");

  AST_AUTO_RATE: assert property (  // RULE4
    @(posedge clk_sys) disable iff (!rstn)
    regs_r[SL_IR][IR_RAUTO] |=>
      out_lane0_rate_hi == $past(rate_det_hi))
    else $error("auto rate mismatch");

  AST_MANUAL_RATE: assert property (  // RULE5
    @(posedge clk_sys) disable iff (!rstn)
    !regs_r[SL_IR][IR_RAUTO] && regs_r[SL_OVR][OV_RATE] |=>
      out_lane0_rate_hi == $past(regs_r[SL_IR][IR_RSEL]))
    else $error("manual rate mismatch");

  AST_PIN_IDLE: assert property (  // RULE17
    @(posedge clk_sys) disable iff (!rstn)
    !regs_r[SL_IR][IR_IAUTO] && !regs_r[SL_OVR][OV_IDLE] |=>
      out_lane0_mute == $past(idle_pin))
    else $error("idle pin not obeyed");

  AST_RESET_VAL: assert property (  // RULE8
    @(posedge clk_sys)
    !rstn |=> regs_r[SL_EQB] == 8'h20 && regs_r[SL_EQA] == 8'h20
      && regs_r[SL_SWG] == 8'h03 && regs_r[SL_DEM] == 8'h03)
    else $error("reset default wrong");

  AST_HOLD: assert property (  // RULE19
    @(posedge clk_sys) disable iff (!rstn)
    !reg_wr ##1 rstn |-> $stable(regs_r[SL_IR])
      && $stable(regs_r[SL_DEM]) && $stable(regs_r[SL_THA]))
    else $error("register changed without write");

  AST_WRITE_READ: assert property (  // RULE18
    @(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == OFS_IDLE_RATE ##1 reg_rd
      && reg_addr == OFS_IDLE_RATE && !reg_wr
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback differs from write");

  AST_EQ_FIELDS: assert property (  // RULE6
    @(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == OFS_EQ_B0 |=>
      {in_b_lane0_equalizer_en, in_b_lane0_gain_stage,
       in_b_lane0_boost_level} == $past(reg_wdata[5:0]))
    else $error("equalizer fields wrong");

  COV_AUTO_MUTE: cover property (
    @(posedge clk_sys) disable iff (!rstn)
    regs_r[SL_IR][IR_IAUTO] && out_lane0_mute);
  COV_PIN_BLOCK: cover property (
    @(posedge clk_sys) disable iff (!rstn)
    regs_r[SL_OVR][OV_IDLE] && idle_pin && !out_lane0_mute);
  COV_EQ_BOOST: cover property (
    @(posedge clk_sys) disable iff (!rstn)
    in_b_lane0_equalizer_en && !in_b_lane0_bypass);

endmodule

// File: rtl/lcc_pkg.sv
/*
  Constants for the lane conditioning configuration bank:
  register offsets, slot map, field positions, reset values
  and the documented setting codes.
  Assumes the importing module uses 8-bit offsets and data.
*/
package lcc_pkg;

  // ---------------------------------------------
  // Widths and slot count
  // ---------------------------------------------
  localparam int AW    = 8;  // Offset width
  localparam int DW    = 8;  // Data width
  localparam int NSLOT = 8;  // Implemented registers
  localparam int SW    = 3;  // Slot index width

  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [AW-1:0] OFS_PIN_OVR   = 8'h08;
  localparam logic [AW-1:0] OFS_IDLE_RATE = 8'h15;
  localparam logic [AW-1:0] OFS_EQ_B0     = 8'h16;
  localparam logic [AW-1:0] OFS_SWING     = 8'h17;
  localparam logic [AW-1:0] OFS_DEEMPH    = 8'h18;
  localparam logic [AW-1:0] OFS_THR_B0    = 8'h19;
  localparam logic [AW-1:0] OFS_EQ_A1     = 8'h1D;
  localparam logic [AW-1:0] OFS_THR_A1    = 8'h20;

  // Slot indices, in offset order
  localparam logic [SW-1:0] SL_OVR = 3'h0;
  localparam logic [SW-1:0] SL_IR  = 3'h1;
  localparam logic [SW-1:0] SL_EQB = 3'h2;
  localparam logic [SW-1:0] SL_SWG = 3'h3;
  localparam logic [SW-1:0] SL_DEM = 3'h4;
  localparam logic [SW-1:0] SL_THB = 3'h5;
  localparam logic [SW-1:0] SL_EQA = 3'h6;
  localparam logic [SW-1:0] SL_THA = 3'h7;

  // Slot to offset, and slot reset values
  localparam logic [AW-1:0] SLOT_OFS [NSLOT] = '{
    OFS_PIN_OVR, OFS_IDLE_RATE, OFS_EQ_B0, OFS_SWING,
    OFS_DEEMPH, OFS_THR_B0, OFS_EQ_A1, OFS_THR_A1};
  localparam logic [DW-1:0] SLOT_RST [NSLOT] = '{
    8'h00, 8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h20, 8'h00};

  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int OV_IDLE   = 4;  // Block idle pin
  localparam int OV_RATE   = 2;  // Block rate pin
  localparam int IR_IAUTO  = 5;  // Automatic idle
  localparam int IR_ISEL   = 4;  // Manual mute
  localparam int IR_RAUTO  = 1;  // Automatic rate
  localparam int IR_RSEL   = 0;  // Manual rate, 1 = high
  localparam int EQ_EN     = 5;  // Equalizer enable
  localparam int EQ_GS_LSB = 3;  // Gain stage [4:3]
  localparam int DE_STYLE  = 7;  // Enhanced when 1
  localparam int TH_DA_LSB = 2;  // De-assert level [3:2]

  // ---------------------------------------------
  // Setting codes
  // ---------------------------------------------
  localparam logic [5:0] EQ_BYPASS = 6'h20;
  localparam logic [6:0] SWG_RSVD  = 7'h3F;
  localparam logic [6:0] SWG_600MV = 7'h03;

endpackage

// File: tb/lcc_host_model.sv
/*
  Host side model of the configuration bank: turns testbench
  requests into single-cycle register strobes.
  Assumes requests arrive registered on clk_sys, one per cycle.
*/
`timescale 1ns/10ps

module lcc_host_model (
  // Requests from the test sequence
  input  logic                    req_wr,
  input  logic                    req_rd,
  input  logic [lcc_pkg::AW-1:0]  req_addr,
  input  logic [lcc_pkg::DW-1:0]  req_wdata,
  // Register port of the bank
  output logic [lcc_pkg::AW-1:0]  reg_addr,
  output logic [lcc_pkg::DW-1:0]  reg_wdata,
  output logic                    reg_wr,
  output logic                    reg_rd
);
  import lcc_pkg::*;

  // ---------------------------------------------
  // Reserved bit masks per offset
  // ---------------------------------------------
  // Software never sets reserved bits, so they are cleared here
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      8'h08:        return 8'h17;
      8'h15:        return 8'h33;
      8'h16, 8'h1D: return 8'h3F;
      8'h17:        return 8'h7F;
      8'h19, 8'h20: return 8'h0F;
      default:      return 8'hFF;
    endcase
  endfunction

  // Strobes follow the request; data masked on the way out
  always_comb begin
    reg_addr  = req_addr;
    reg_wr    = req_wr;
    reg_rd    = req_rd;
    reg_wdata = req_wdata & keep_mask(req_addr);
  end
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench for the lane conditioning bank.
  Assumes the host model sits between sequence and bank.
*/
`timescale 1ns/10ps

module testbench;
  import lcc_pkg::*;

  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  logic clk_sys, rstn, req_wr, req_rd, reg_wr, reg_rd, reg_hit;
  logic [7:0] req_addr, req_wdata, reg_addr, reg_wdata, reg_rdata;
  logic idle_pin, rate_pin, elec_idle_det, rate_det_hi;
  logic mute, sdet, rate_hi, swg_rsvd, de_style;
  logic [6:0] swing, deemph;
  logic b_en, b_byp, a_en, a_byp;
  logic [1:0] b_gs, a_gs, b_da, b_as, a_da, a_as;
  logic [2:0] b_bl, a_bl;
  int err_count;
  int n_tests;

  // ---------------------------------------------
  // Instances
  // ---------------------------------------------
  lcc_host_model host (.req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr),
    .req_wdata(req_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  lcc_config_regs uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .idle_pin(idle_pin),
    .rate_pin(rate_pin), .elec_idle_det(elec_idle_det),
    .rate_det_hi(rate_det_hi), .out_lane0_mute(mute),
    .out_lane0_signal_detection_en(sdet), .out_lane0_rate_hi(rate_hi),
    .out_lane0_output_swing(swing), .out_lane0_swing_rsvd(swg_rsvd),
    .out_lane0_deemphasis_style(de_style), .out_lane0_deemphasis(deemph),
    .in_b_lane0_equalizer_en(b_en), .in_b_lane0_gain_stage(b_gs),
    .in_b_lane0_boost_level(b_bl), .in_b_lane0_bypass(b_byp),
    .in_b_lane0_idle_deassert(b_da), .in_b_lane0_idle_assert(b_as),
    .in_a_lane1_equalizer_en(a_en), .in_a_lane1_gain_stage(a_gs),
    .in_a_lane1_boost_level(a_bl), .in_a_lane1_bypass(a_byp),
    .in_a_lane1_idle_deassert(a_da), .in_a_lane1_idle_assert(a_as));

  // ---------------------------------------------
  // Clock and shared tasks
  // ---------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Write lands at the second edge; fields settle by return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req_wr <= 1'b1;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req_wr <= 1'b0;
    #1;
  endtask

  // Read with hit checked in the strobe cycle, data one cycle on
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk_sys);
    req_rd <= 1'b1;
    req_addr <= a;
    #1 chk(reg_hit, hit);
    @(posedge clk_sys);
    req_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Program lane mode and sources, then check registered outputs
  task automatic lane(input logic [7:0] ovr, input logic [7:0] ir,
                      input logic [3:0] src, input logic [2:0] exp);
    wr(8'h08, ovr);
    wr(8'h15, ir);
    @(posedge clk_sys);
    {idle_pin, rate_pin, elec_idle_det, rate_det_hi} <= src;
    repeat (2) @(posedge clk_sys);
    #1 chk({mute, sdet, rate_hi}, exp);
  endtask

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  logic [7:0] ofs [8] = '{8'h08, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1D, 8'h20};
  logic [7:0] dflt [8] = '{8'h00, 8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h20, 8'h00};
  logic [7:0] msk [8] = '{8'h17, 8'h33, 8'h3F, 8'h7F, 8'hFF, 8'h0F, 8'h3F, 8'h0F};
  logic [5:0] eqc [9] = '{6'h20, 6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, 6'h3B, 6'h3D};
  logic [7:0] swc [5] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
  logic [7:0] dec [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};

  initial begin
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    {req_wr, req_rd, req_addr, req_wdata} = '0;
    {idle_pin, rate_pin, elec_idle_det, rate_det_hi} = '0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    // Defaults at the ports and on readback
    #1 chk({6'h00, b_byp, a_byp}, 8'h03);
    chk({1'b0, swing}, 8'h03);
    for (int i = 0; i < 8; i++) rchk(ofs[i], dflt[i], 1'b1);
    // Every writable bit stored, registers independent
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'hFF);
    for (int i = 0; i < 8; i++) rchk(ofs[i], msk[i], 1'b1);
    // Unmapped offset ignored and reads zero
    wr(8'h30, 8'hAA);
    rchk(8'h30, 8'h00, 1'b0);
    // Equalizer coding on both inputs, each kept apart
    foreach (eqc[i]) begin
      wr(8'h16, {2'b00, eqc[i]});
      wr(8'h1D, {2'b00, eqc[8-i]});
      chk({b_en, b_gs, b_bl}, eqc[i]);
      chk(b_byp, eqc[i] == 6'h20);
      chk({a_en, a_gs, a_bl}, eqc[8-i]);
      chk(a_byp, eqc[8-i] == 6'h20);
    end
    // Swing and de-emphasis codes
    foreach (swc[i]) begin
      wr(8'h17, swc[i]);
      wr(8'h18, dec[i]);
      chk({swg_rsvd, swing}, {swc[i] == 8'h3F, swc[i][6:0]});
      chk({de_style, deemph}, dec[i]);
    end
    // Idle thresholds, all level pairs on both inputs
    for (int i = 0; i < 16; i++) begin
      wr(8'h19, 8'(i));
      wr(8'h20, 8'(15 - i));
      chk({b_da, b_as}, 8'(i));
      chk({a_da, a_as}, 8'(15 - i));
    end
    // Lane 0 idle and rate control: src is pins then detectors
    lane(8'h00, 8'h00, 4'b1001, 3'b100);
    lane(8'h00, 8'h11, 4'b0110, 3'b001);
    lane(8'h14, 8'h10, 4'b0101, 3'b100);
    lane(8'h14, 8'h01, 4'b1010, 3'b001);
    lane(8'h14, 8'h22, 4'b0110, 3'b110);
    lane(8'h14, 8'h33, 4'b1101, 3'b011);
    lane(8'h00, 8'h22, 4'b1001, 3'b011);
    // Write then read back to back on one offset
    @(posedge clk_sys);
    req_wr <= 1'b1;
    req_addr <= 8'h15;
    req_wdata <= 8'h12;
    @(posedge clk_sys);
    req_wr <= 1'b0;
    req_rd <= 1'b1;
    @(posedge clk_sys);
    req_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h12);
    // Second reset restores defaults
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    // Read data and lane controls cleared by the reset edge
    #1 chk(reg_rdata, 8'h00);
    chk({mute, sdet, rate_hi}, 3'b000);
    rchk(8'h17, 8'h03, 1'b1);
    rchk(8'h16, 8'h20, 1'b1);
    complete_run();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
